// File: core/cies_ctrl.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cies_map.svh"

module cies_ctrl #(
  parameter int NUM_IRQ = 32,
  // Identity values are arbitrary
  parameter logic [7:0] IMPL_CODE = 8'h5a,
  parameter logic [3:0] ARCH_CODE = 4'h3,
  parameter logic [11:0] MODEL_NUM = 12'h123,
  parameter logic [3:0] REV_NUM = 4'h1
) (
  // Clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Non-maskable request pin
  input wire logic nmiPin,
  // Core and interrupt controller side
  input wire logic [NUM_IRQ-1:0] irqPendIn,
  input wire logic [NUM_IRQ-1:0] irqEnableIn,
  input wire logic excEntry,
  input wire cies_pkg::cies_exc_t excEntryNum,
  input wire logic excReturn,
  input wire cies_pkg::cies_exc_t excReturnNum,
  input wire logic debugHalted,
  // Pending state toward the core
  output logic nmiPending,
  output logic deferredPending,
  output logic tickPending,
  output cies_pkg::cies_exc_t topPendingNum,
  // Interrupt
  output logic irqOut
);
  import cies_pkg::*;

  // Bus address phase capture
  cies_dphase_t dPhase_q;
  logic [11:0] dOfs_q;
  logic hit;
  logic take;
  logic [31:0] rdData;
  logic [31:0] hrdata_q;
  logic [11:0] aOfs;
  logic [19:0] baseHi;
  logic rdTake;

  // Write strobes decoded in data phase
  logic wrIcs;
  logic wrEvStat;
  logic wrEvMask;

  // Exception state
  logic nmiPend_q;
  logic dsPend_q;
  logic tickPend_q;
  cies_exc_t active_q;
  cies_exc_t topNum;
  logic preempt;
  logic irqAny;

  // Non-maskable pin synchroniser
  logic nmiS1_q;
  logic nmiS2_q;
  logic nmiS3_q;
  logic nmiLvl_q;
  logic nmiRise;

  // Event status and mask
  cies_ev_t evStat_q;
  cies_ev_t evMask_q;
  cies_ev_t evSet;

  // Upper address bits select the control space
  assign baseHi = 20'(`CIES_BASE >> 12);
  assign aOfs = {haddr[11:2], 2'b00};
  assign hit = hsel && (haddr[31:12] == baseHi);
  assign take = hit && htrans[1] && hready;
  assign rdTake = take && !hwrite;

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      dPhase_q <= CIES_DP_IDLE;
      dOfs_q <= 12'h000;
    end else if (hready) begin
      if (take) begin
        dPhase_q <= hwrite ? CIES_DP_WRITE : CIES_DP_READ;
        dOfs_q <= aOfs;
      end else begin
        dPhase_q <= CIES_DP_IDLE;
      end
    end
  end

  always_comb begin
    wrIcs = 1'b0;
    wrEvStat = 1'b0;
    wrEvMask = 1'b0;
    case (dPhase_q)
      CIES_DP_WRITE: begin
        wrIcs = (dOfs_q == `CIES_OFS_ICS);
        wrEvStat = (dOfs_q == `CIES_OFS_EVSTAT);
        wrEvMask = (dOfs_q == `CIES_OFS_EVMASK);
      end
      CIES_DP_READ: begin
        wrIcs = 1'b0;
      end
      CIES_DP_IDLE: begin
        wrIcs = 1'b0;
      end
      default: begin
        wrIcs = 1'b0;
      end
    endcase
  end

  // Pin settles once second and third stages agree
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      nmiS1_q <= 1'b0;
      nmiS2_q <= 1'b0;
      nmiS3_q <= 1'b0;
      nmiLvl_q <= 1'b0;
    end else begin
      nmiS1_q <= nmiPin;
      nmiS2_q <= nmiS1_q;
      nmiS3_q <= nmiS2_q;
      if (nmiS2_q == nmiS3_q) begin
        nmiLvl_q <= nmiS3_q;
      end
    end
  end

  assign nmiRise = (nmiS2_q == nmiS3_q) && nmiS3_q && !nmiLvl_q;

  // Non-maskable pending: set wins over handler-entry clear
  logic nmiSetSw;
  logic nmiClrEntry;
  assign nmiSetSw = wrIcs && hwdata[`CIES_ICS_NMI_SET];
  assign nmiClrEntry = excEntry &&
    (excEntryNum == `CIES_EXC_NMI);

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      nmiPend_q <= 1'b0;
    end else if (nmiSetSw || nmiRise) begin
      nmiPend_q <= 1'b1;
    end else if (nmiClrEntry) begin
      nmiPend_q <= 1'b0;
    end
  end

  // Deferred service: software is the only setter
  logic dsSet;
  logic dsClr;
  logic dsClrEntry;
  assign dsSet = wrIcs && hwdata[`CIES_ICS_DS_SET];
  // Handler entry drops the pending state as well
  assign dsClrEntry = excEntry &&
    (excEntryNum == `CIES_EXC_DS);
  // Clear needs set bit low in the same write
  assign dsClr = (wrIcs && hwdata[`CIES_ICS_DS_CLR] &&
    !hwdata[`CIES_ICS_DS_SET]) ||
    dsClrEntry;

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      dsPend_q <= 1'b0;
    end else if (dsSet) begin
      dsPend_q <= 1'b1;
    end else if (dsClr) begin
      dsPend_q <= 1'b0;
    end
  end

  // System tick pending
  logic tickSet;
  logic tickClr;
  logic tickClrEntry;
  assign tickSet = wrIcs && hwdata[`CIES_ICS_TICK_SET];
  // Handler entry drops the pending state as well
  assign tickClrEntry = excEntry &&
    (excEntryNum == `CIES_EXC_TICK);
  assign tickClr = (wrIcs && hwdata[`CIES_ICS_TICK_CLR] &&
    !hwdata[`CIES_ICS_TICK_SET]) ||
    tickClrEntry;

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      tickPend_q <= 1'b0;
    end else if (tickSet) begin
      tickPend_q <= 1'b1;
    end else if (tickClr) begin
      tickPend_q <= 1'b0;
    end
  end

  // Active exception tracking
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      active_q <= 9'h000;
    end else if (excEntry) begin
      active_q <= excEntryNum;
    end else if (excReturn) begin
      active_q <= excReturnNum;
    end
  end

  // Lowest pending enabled number wins
  always_comb begin
    topNum = 9'h000;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irqPendIn[i] && irqEnableIn[i]) begin
        topNum = `CIES_EXC_IRQ0 + 9'(i);
      end
    end
    if (tickPend_q) begin
      topNum = `CIES_EXC_TICK;
    end
    if (dsPend_q) begin
      topNum = `CIES_EXC_DS;
    end
    if (nmiPend_q) begin
      topNum = `CIES_EXC_NMI;
    end
  end

  // Bit 22 ignores enables; ranking does not
  assign irqAny = (|irqPendIn) || dsPend_q || tickPend_q;
  assign preempt = debugHalted && (topNum != 9'h000) &&
    ((active_q == 9'h000) || (topNum < active_q));

  // Event status, set wins over write-one clear
  assign evSet = {
    excReturn,
    excEntry,
    tickSet,
    dsSet,
    nmiSetSw || nmiRise
  };

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      evStat_q <= `CIES_EV_RESET;
    end else if (wrEvStat) begin
      evStat_q <= (evStat_q & ~hwdata[4:0]) | evSet;
    end else begin
      evStat_q <= evStat_q | evSet;
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      evMask_q <= `CIES_MASK_RESET;
    end else if (wrEvMask) begin
      evMask_q <= hwdata[4:0];
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(evStat_q & evMask_q);
    end
  end

  // Read mux, reserved bits zero
  always_comb begin
    rdData = 32'h00000000;
    case (aOfs)
      `CIES_OFS_ID: begin
        rdData[`CIES_ID_IMPL] = IMPL_CODE;
        rdData[`CIES_ID_ARCH] = ARCH_CODE;
        rdData[`CIES_ID_MODEL] = MODEL_NUM;
        rdData[`CIES_ID_REV] = REV_NUM;
      end
      `CIES_OFS_ICS: begin
        rdData[`CIES_ICS_NMI_SET] = nmiPend_q;
        rdData[`CIES_ICS_DS_SET] = dsPend_q;
        rdData[`CIES_ICS_TICK_SET] = tickPend_q;
        rdData[`CIES_ICS_PREEMPT] = preempt;
        rdData[`CIES_ICS_IRQ_PEND] = irqAny;
        rdData[`CIES_ICS_TOP_PEND] = topNum;
        rdData[`CIES_ICS_ACTIVE] = active_q;
      end
      `CIES_OFS_EVSTAT: begin
        rdData[4:0] = evStat_q;
      end
      `CIES_OFS_EVMASK: begin
        rdData[4:0] = evMask_q;
      end
      default: begin
        rdData = 32'h00000000;
      end
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h00000000;
    end else if (rdTake) begin
      hrdata_q <= rdData;
    end
  end

  // Zero wait states, response always OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign nmiPending = nmiPend_q;
  assign deferredPending = dsPend_q;
  assign tickPending = tickPend_q;
  assign topPendingNum = topNum;

endmodule // cies_ctrl

// File: core/cies_map.svh
`ifndef CIES_MAP_SVH
`define CIES_MAP_SVH
// Control space base and register offsets
`define CIES_BASE 32'he000e000
`define CIES_OFS_ID 12'hd00
`define CIES_OFS_ICS 12'hd04
`define CIES_OFS_EVSTAT 12'hd40
`define CIES_OFS_EVMASK 12'hd44
// Identification fields
`define CIES_ID_IMPL 31:24
`define CIES_ID_ARCH 19:16
`define CIES_ID_MODEL 15:4
`define CIES_ID_REV 3:0
// Interrupt control state fields
`define CIES_ICS_NMI_SET 31
`define CIES_ICS_DS_SET 28
`define CIES_ICS_DS_CLR 27
`define CIES_ICS_TICK_SET 26
`define CIES_ICS_TICK_CLR 25
`define CIES_ICS_PREEMPT 23
`define CIES_ICS_IRQ_PEND 22
`define CIES_ICS_TOP_PEND 20:12
`define CIES_ICS_ACTIVE 8:0
`define CIES_ICS_RESET 32'h00000000
// Event status bit positions
`define CIES_EV_NMI 0
`define CIES_EV_DS 1
`define CIES_EV_TICK 2
`define CIES_EV_ENTRY 3
`define CIES_EV_RETURN 4
`define CIES_EV_RESET 5'h00
`define CIES_MASK_RESET 5'h00
// Exception numbers
`define CIES_EXC_NMI 9'h002
`define CIES_EXC_DS 9'h00e
`define CIES_EXC_TICK 9'h00f
`define CIES_EXC_IRQ0 9'h010
`endif

// File: core/cies_pkg.sv
package cies_pkg;
  typedef logic [8:0] cies_exc_t;
  typedef logic [4:0] cies_ev_t;
  typedef enum logic [1:0] {
    CIES_DP_IDLE = 2'b00,
    CIES_DP_READ = 2'b01,
    CIES_DP_WRITE = 2'b10
  } cies_dphase_t;
endpackage

// File: tb/cies_ctrl_props.sv
`timescale 1ns/1ps
module cies_ctrl_props
#(
  parameter int NUM_IRQ = 32
) (
  // Clock and bus
  input wire logic sysClk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Core side
  input wire logic nmiPin,
  input wire logic [NUM_IRQ-1:0] irqPendIn,
  input wire logic [NUM_IRQ-1:0] irqEnableIn,
  input wire logic excEntry,
  input wire cies_pkg::cies_exc_t excEntryNum,
  input wire logic nmiPending,
  input wire logic deferredPending,
  input wire logic tickPending,
  input wire cies_pkg::cies_exc_t topPendingNum
);
  import cies_pkg::*;
  // Data phase of a control state access: {write, read}
  logic [1:0] ph_q;
  wire take = hsel && htrans[1] && hready && haddr == 32'he000ed04;
  always_ff @(posedge sysClk or posedge rst)
    if (rst)
      ph_q <= 2'h0;
    else
      ph_q <= {take & hwrite, take & ~hwrite};
  default clocking @(posedge sysClk); endclocking
  default disable iff (rst);
  a_nmi_set: assert property (ph_q[1] && hwdata[31] |=> nmiPending)
    else $error("nmi set lost");
  a_ds_set: assert property (ph_q[1] && hwdata[28] |=> deferredPending)
    else $error("deferred set lost");
  a_ds_clear: assert property (ph_q[1] && hwdata[28:27] == 2'b01
    |=> !deferredPending) else $error("deferred clear lost");
  a_tick_set: assert property (ph_q[1] && hwdata[26] |=> tickPending)
    else $error("tick set lost");
  a_tick_clear: assert property (ph_q[1] && hwdata[26:25] == 2'b01
    |=> !tickPending) else $error("tick clear lost");
  a_ds_only_sw: assert property ($rose(deferredPending)
    |-> $past(ph_q[1] && hwdata[28])) else $error("deferred set unasked");
  a_nmi_entry_clear: assert property (excEntry && excEntryNum == 9'h002
    && !nmiPin && !ph_q[1] |=> !nmiPending) else $error("nmi kept");
  a_top_idle: assert property (!nmiPending && !deferredPending
    && !tickPending && !(|(irqPendIn & irqEnableIn))
    |-> topPendingNum == 9'h000) else $error("top not zero");
  a_rsvd_zero: assert property (ph_q[0] |->
    (hrdata & 32'h6b200e00) == 32'h0) else $error("reserved bits set");
  cover property (ph_q[1] && hwdata[28:27] == 2'b01 ##1 !deferredPending);
  cover property (excEntry && nmiPending);
  cover property (topPendingNum > 9'h00f);
endmodule // cies_ctrl_props

bind cies_ctrl cies_ctrl_props #(.NUM_IRQ(NUM_IRQ)) i_cies_ctrl_props (
  .sysClk(sysClk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .nmiPin(nmiPin), .irqPendIn(irqPendIn),
  .irqEnableIn(irqEnableIn), .excEntry(excEntry),
  .excEntryNum(excEntryNum), .nmiPending(nmiPending),
  .deferredPending(deferredPending), .tickPending(tickPending),
  .topPendingNum(topPendingNum));

// File: tb/cies_ctrl_tb.sv
`timescale 1ns/1ps
module cies_ctrl_tb;
  import cies_pkg::*;
  // Identity values are arbitrary
  localparam logic [31:0] IDW = 32'h5a031231;
  logic sysClk = 0, rst = 1, hsel = 0, hwrite = 0, nmiPin = 0, rdPh = 0;
  logic excEntry = 0, excReturn = 0, debugHalted = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, pend = 0, ena = 0, rnd = 32'ha72d;
  logic [31:0] hrdata, sb, tw;
  logic [31:0] expq[$];
  cies_exc_t eNum = 0, topPendingNum;
  logic hreadyout, hresp, nmiPending, deferredPending, tickPending, irqOut;
  int fails = 0, n_compared = 0, cyc = 0;
  cies_ctrl #(.NUM_IRQ(32)) i_cies_ctrl (
    .sysClk(sysClk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .nmiPin(nmiPin), .irqPendIn(pend), .irqEnableIn(ena),
    .excEntry(excEntry), .excEntryNum(eNum), .excReturn(excReturn),
    .excReturnNum(eNum), .debugHalted(debugHalted),
    .nmiPending(nmiPending), .deferredPending(deferredPending),
    .tickPending(tickPending), .topPendingNum(topPendingNum),
    .irqOut(irqOut));
  initial forever #12.5 sysClk = ~sysClk;
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge sysClk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'he000e, a};
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    rdPh <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic core(logic r, cies_exc_t n);
    @(posedge sysClk);
    excEntry <= !r;
    excReturn <= r;
    eNum <= n;
    @(posedge sysClk);
    excEntry <= 1'b0;
    excReturn <= 1'b0;
  endtask
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Read data checked in the data phase, oldest note first
  always @(posedge sysClk) begin
    cyc++;
    if (rdPh && hreadyout) begin
      chk("hrdata", expq.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge sysClk);
    rst <= 1'b0;
    rd(12'hd00, IDW);
    rd(12'hd08, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      wr(12'hd00, rnd);
      wr(12'hd04, rnd & 32'h6b200e00);
      rd(12'hd00, IDW);
      rd(12'hd04, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      sb = k ? 32'h04000000 : 32'h10000000;
      tw = k ? 32'h0040f000 : 32'h0040e000;
      wr(12'hd04, sb);
      rd(12'hd04, sb | tw);
      wr(12'hd04, sb | sb >> 1);
      rd(12'hd04, sb | tw);
      wr(12'hd04, sb >> 1);
      rd(12'hd04, 32'h0);
    end
    wr(12'hd04, 32'h14000000);
    rd(12'hd04, 32'h1440e000);
    wr(12'hd04, 32'h0a000000);
    wr(12'hd04, 32'h80000000);
    rd(12'hd04, 32'h80002000);
    core(1'b0, 9'h002);
    rd(12'hd04, 32'h00000002);
    nmiPin <= 1'b1;
    repeat (6) @(posedge sysClk);
    nmiPin <= 1'b0;
    rd(12'hd04, 32'h80002002);
    core(1'b0, 9'h002);
    core(1'b1, 9'h000);
    rd(12'hd04, 32'h0);
    pend <= 32'h8;
    ena <= 32'h8;
    debugHalted <= 1'b1;
    core(1'b0, 9'h010);
    rd(12'hd04, 32'h00413010);
    core(1'b1, 9'h000);
    rd(12'hd04, 32'h00c13000);
    ena <= 32'h0;
    rd(12'hd04, 32'h00400000);
    pend <= 32'h0;
    debugHalted <= 1'b0;
    wr(12'hd40, 32'h1f);
    rd(12'hd40, 32'h0);
    wr(12'hd44, 32'h2);
    wr(12'hd04, 32'h04000000);
    rd(12'hd40, 32'h4);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    wr(12'hd04, 32'h10000000);
    rd(12'hd40, 32'h6);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    wr(12'hd40, 32'h6);
    rd(12'hd44, 32'h2);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    core(1'b0, 9'h00e);
    rd(12'hd04, 32'h0440f00e);
    core(1'b1, 9'h000);
    // Reset in mid-run with tick still pending
    rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    rd(12'hd04, 32'h0);
    rd(12'hd44, 32'h0);
    repeat (3) @(posedge sysClk);
    end_of_test();
  end
endmodule // cies_ctrl_tb
